// ===== verilog/hs_coding_pkg.sv
// Purpose: Shared constants for the instrument bus message coding and handshake block.
// Assumes: Device pins are positive logic.
// Notes:   Command group codes live in bits 7..6 of a seven-bit command byte.
package hs_coding_pkg;

  // Width of a bus byte and of the command field.
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned CMD_W    = 7;
  localparam int unsigned ADDR_W   = 5;

  // Position of the group field inside the command byte.
  localparam int unsigned GRP_LSB  = 5;
  localparam int unsigned GRP_W    = 2;

  // Bits 7..6 group codes (bit 5 splits universal from addressed).
  localparam logic [1:0] GRP_PRIM  = 2'h0;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK  = 2'h2;
  localparam logic [1:0] GRP_SEC   = 2'h3;

  // Bit that separates universal from addressed commands in the primary group.
  localparam int unsigned UNIV_BIT = 4;

  // Reserved all-ones address meaning unlisten or untalk.
  localparam logic [4:0] ADDR_ALL  = 5'h1F;

  // Default device address.
  localparam logic [4:0] ADDR_DFLT = 5'h00;

  // Clock rate and the settle time granted to the data lines before data valid is driven.
  localparam int unsigned CLK_HZ      = 20000000;
  localparam int unsigned SETTLE_NS   = 100;
  localparam int unsigned SETTLE_CYC  =
    (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000 < 1 ? 1 :
    (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // Source and acceptor handshake states.
  typedef enum logic [2:0] {
    SRC_IDLE,
    SRC_GEN,
    SRC_DLY,
    SRC_TRANS,
    SRC_WAIT
  } src_state_t;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READY,
    ACC_ACCEPT,
    ACC_DONE
  } acc_state_t;

endpackage : hs_coding_pkg

// ===== verilog/cmd_decoder.sv
// Purpose: Decodes a command byte into address and group events.
// Assumes: valid_i is a one-cycle strobe in the accept state.
// Notes:   Outputs are registered one-cycle pulses.
`timescale 1ns/1ps
module cmd_decoder (
  input  wire logic       clk_i,       // System clock.
  input  wire logic       rst_n_i,     // Synchronised reset, active low.
  input  wire logic       valid_i,     // Byte strobe.
  input  wire logic [7:0] byte_i,      // Received command byte.
  input  wire logic [4:0] my_addr_i,   // This device's address.
  output logic            my_listen_o, // My listen address seen.
  output logic            my_talk_o,   // My talk address seen.
  output logic            unlisten_o,  // Unlisten seen.
  output logic            untalk_o,    // Untalk seen.
  output logic            other_talk_o,// Another device's talk address.
  output logic            univ_o,      // Universal command.
  output logic            addrd_o,     // Addressed command.
  output logic            sec_o        // Secondary command.
);

  // Group field from bits 7..6 of the seven bits kept.
  function automatic logic [1:0] grp_of(input logic [7:0] b);
    grp_of = b[hs_coding_pkg::GRP_LSB +: hs_coding_pkg::GRP_W];
  endfunction : grp_of

  logic [1:0] grp;  // Group of the current byte.
  logic [4:0] adr;  // Five low address bits.
  assign grp = grp_of(byte_i);
  assign adr = byte_i[hs_coding_pkg::ADDR_W-1:0];

  // Registered decode; bit 8 of the byte never takes part.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      my_listen_o  <= 1'b0;
      my_talk_o    <= 1'b0;
      unlisten_o   <= 1'b0;
      untalk_o     <= 1'b0;
      other_talk_o <= 1'b0;
      univ_o       <= 1'b0;
      addrd_o      <= 1'b0;
      sec_o        <= 1'b0;
    end else begin
      my_listen_o  <= valid_i && grp == hs_coding_pkg::GRP_LISTEN
                      && adr != hs_coding_pkg::ADDR_ALL && adr == my_addr_i;
      unlisten_o   <= valid_i && grp == hs_coding_pkg::GRP_LISTEN
                      && adr == hs_coding_pkg::ADDR_ALL;
      my_talk_o    <= valid_i && grp == hs_coding_pkg::GRP_TALK
                      && adr != hs_coding_pkg::ADDR_ALL && adr == my_addr_i;
      untalk_o     <= valid_i && grp == hs_coding_pkg::GRP_TALK
                      && adr == hs_coding_pkg::ADDR_ALL;
      other_talk_o <= valid_i && grp == hs_coding_pkg::GRP_TALK
                      && adr != hs_coding_pkg::ADDR_ALL && adr != my_addr_i;
      univ_o       <= valid_i && grp == hs_coding_pkg::GRP_PRIM
                      && byte_i[hs_coding_pkg::UNIV_BIT];
      addrd_o      <= valid_i && grp == hs_coding_pkg::GRP_PRIM
                      && !byte_i[hs_coding_pkg::UNIV_BIT];
      sec_o        <= valid_i && grp == hs_coding_pkg::GRP_SEC;
    end
  end

endmodule : cmd_decoder

// ===== verilog/settle_timer.sv
// Purpose: Counts a fixed settle time after a start pulse.
// Assumes: Start may retrigger at any time.
// Notes:   Done is a level that stays high until the next start.
`timescale 1ns/1ps
module settle_timer #(
  parameter int unsigned CYCLES = 2  // Cycles to wait.
) (
  input  wire logic clk_i,    // System clock.
  input  wire logic rst_n_i,  // Synchronised reset, active low.
  input  wire logic start_i,  // Restart the count.
  output logic      done_o    // Count finished.
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q;  // Remaining cycles.

  // Load on start, then count down to zero.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (start_i) begin
      cnt_q <= CW'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done_o = (cnt_q == '0) && !start_i;

endmodule : settle_timer

// ===== verilog/bus_handshake.sv
// Purpose: Message coding and three-wire byte handshake for an instrument bus port.
// Assumes: Pins are positive logic; transceivers invert; inputs synchronous to ref_clk_i.
// Notes:   Talker, listener and controller state machines stay outside; this block
//          tracks only the addressed and primary state needed to qualify addressed and secondary commands.
//
// Contract
// - One multiline byte, many uniline lines at once
// - Command decode ignores data bit eight
// - Bits 7..6 = 01 is listen address
// - Listen all-ones address means unlisten
// - Bits 7..6 = 10 talk; all-ones untalk
// - Addressed commands only when already addressed
// - Secondary only right after a primary
// - Uniline messages act immediately, unqualified
// - Bytes valid only in transfer/accept states
// - Passive values drive line state zero
// - One full handshake per byte
// - Asynchronous pace set by slowest acceptor
// - Reset: data not valid, not ready, not accepted
// - Ready and accepted both high is error
// - Assert valid; acceptors drop ready
// - Accepted high only after slowest acceptor
// - Accepted seen: withdraw valid; then drop accepted
// - No step before previous step completes
// - Bus lines are negative logic
// - Device pins carry positive-logic complements
`timescale 1ns/1ps
module bus_handshake #(
  parameter int unsigned SETTLE = hs_coding_pkg::SETTLE_CYC  // Data settle cycles.
) (
  input  wire logic       ref_clk_i,     // System clock, 20 MHz.
  input  wire logic       nrst_i,        // Asynchronous reset, active low.
  // Local address and role.
  input  wire logic [4:0] my_addr_i,     // Device address.
  // Source side user port.
  input  wire logic       tx_valid_i,    // Byte to send.
  input  wire logic [7:0] tx_data_i,     // Byte value.
  output logic            tx_ready_o,    // Byte taken for sending.
  output logic            tx_done_o,     // Byte accepted by all, pulse.
  output logic            src_err_o,     // No acceptor present, level.
  // Acceptor side user port.
  input  wire logic       rx_enable_i,   // Acceptor active (listening or ATN).
  input  wire logic       rx_hold_i,     // Local side not ready for more.
  output logic            rx_valid_o,    // Received byte strobe.
  output logic [7:0]      rx_data_o,     // Received byte.
  // Decoded command events.
  output logic            my_listen_o,   // Addressed to listen, pulse.
  output logic            my_talk_o,     // Addressed to talk, pulse.
  output logic            unlisten_o,    // Unlisten, pulse.
  output logic            untalk_o,      // Untalk, pulse.
  output logic            addrd_cmd_o,   // Qualified addressed command, pulse.
  output logic            univ_cmd_o,    // Universal command, pulse.
  output logic            sec_cmd_o,     // Qualified secondary command, pulse.
  output logic            listener_o,    // Device is addressed as listener.
  output logic            talker_o,      // Device is addressed as talker.
  // Uniline messages, positive logic.
  input  wire logic       atn_i,         // Attention.
  input  wire logic       ifc_i,         // Interface clear.
  input  wire logic       ren_i,         // Remote enable.
  output logic            atn_o,         // Attention seen.
  output logic            ifc_o,         // Interface clear seen.
  output logic            ren_o,         // Remote enable seen.
  // Handshake pins, positive logic complements of the bus lines.
  input  wire logic       dav_i,         // Data valid sensed.
  output logic            dav_o,         // Data valid driven.
  output logic            dav_oe_n_o,    // Drive enable for data valid, low drives.
  input  wire logic       rfd_i,         // Ready for data sensed.
  output logic            rfd_o,         // Ready for data driven.
  output logic            rfd_oe_n_o,    // Drive enable for ready, low drives.
  input  wire logic       dac_i,         // Data accepted sensed.
  output logic            dac_o,         // Data accepted driven.
  output logic            dac_oe_n_o,    // Drive enable for accepted, low drives.
  // Data lines, positive logic.
  input  wire logic [7:0] dio_i,         // Data lines sensed.
  output logic [7:0]      dio_o,         // Data lines driven.
  output logic            dio_oe_n_o     // Drive enable for data lines, low drives.
);

  ////////////////////////////////////////
  // Reset release.

  logic [1:0] rst_sync_q;  // Two-stage reset release.
  logic       rst_n;       // Released reset for the whole block.

  // Assertion is asynchronous, release waits for two edges.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////
  // Uniline messages.

  // Uniline lines pass straight through; they need no handshake qualification.
  assign atn_o = atn_i;
  assign ifc_o = ifc_i;
  assign ren_o = ren_i;

  ////////////////////////////////////////
  // Source handshake.

  hs_coding_pkg::src_state_t src_q;  // Source state.
  logic [7:0] tx_byte_q;             // Byte held on the data lines.
  logic       settle_go;             // Start of the data settle time.
  logic       settle_done;           // Data has settled.
  logic       src_err_q;             // Ready and accepted both high.

  // A fresh byte restarts the settle timer.
  assign settle_go  = (src_q == hs_coding_pkg::SRC_GEN);
  assign tx_ready_o = (src_q == hs_coding_pkg::SRC_IDLE) && !atn_i;

  settle_timer #(
    .CYCLES (SETTLE)
  ) u_settle (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n),
    .start_i (settle_go),
    .done_o  (settle_done)
  );

  // Source sequence: take byte, settle, wait for ready, drive valid,
  // wait for accepted, withdraw valid, wait for accepted to drop.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      src_q     <= hs_coding_pkg::SRC_IDLE;
      tx_byte_q <= 8'h00;
      tx_done_o <= 1'b0;
    end else begin
      tx_done_o <= 1'b0;
      case (src_q)
        hs_coding_pkg::SRC_IDLE: begin
          // Only one multiline byte may be offered at a time.
          if (tx_valid_i && !atn_i) begin
            tx_byte_q <= tx_data_i;
            src_q     <= hs_coding_pkg::SRC_GEN;
          end
        end
        hs_coding_pkg::SRC_GEN: begin
          src_q <= hs_coding_pkg::SRC_DLY;
        end
        hs_coding_pkg::SRC_DLY: begin
          // Wait until all acceptors are ready.
          if (settle_done && rfd_i && !dac_i) begin
            src_q <= hs_coding_pkg::SRC_TRANS;
          end
        end
        hs_coding_pkg::SRC_TRANS: begin
          // Accepted seen: withdraw valid.
          if (dac_i) begin
            src_q     <= hs_coding_pkg::SRC_WAIT;
            tx_done_o <= 1'b1;
          end
        end
        hs_coding_pkg::SRC_WAIT: begin
          // Next byte only once acceptors have dropped accepted.
          if (!dac_i) begin
            src_q <= hs_coding_pkg::SRC_IDLE;
          end
        end
        default: begin
          src_q <= hs_coding_pkg::SRC_IDLE;
        end
      endcase
    end
  end

  // Ready and accepted both high before valid: nobody listens.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      src_err_q <= 1'b0;
    end else begin
      src_err_q <= (src_q == hs_coding_pkg::SRC_DLY) && rfd_i && dac_i;
    end
  end
  assign src_err_o = src_err_q;

  // Data valid only in transfer; data held until withdrawal.
  assign dav_o      = (src_q == hs_coding_pkg::SRC_TRANS);
  assign dav_oe_n_o = !dav_o;
  assign dio_o      = tx_byte_q;
  assign dio_oe_n_o = (src_q == hs_coding_pkg::SRC_IDLE);

  ////////////////////////////////////////
  // Acceptor handshake.

  hs_coding_pkg::acc_state_t acc_q;  // Acceptor state.
  logic rx_strobe;                   // Byte taken this cycle.

  assign rx_strobe = (acc_q == hs_coding_pkg::ACC_ACCEPT);

  // Acceptor sequence: ready, see valid, take byte, release accepted,
  // wait for valid to drop, then drop accepted again.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= hs_coding_pkg::ACC_IDLE;
    end else begin
      case (acc_q)
        hs_coding_pkg::ACC_IDLE: begin
          if ((rx_enable_i || atn_i) && !rx_hold_i && !dav_i) begin
            acc_q <= hs_coding_pkg::ACC_READY;
          end
        end
        hs_coding_pkg::ACC_READY: begin
          // Valid seen: ready drops next state.
          if (dav_i) begin
            acc_q <= hs_coding_pkg::ACC_ACCEPT;
          end else if (!(rx_enable_i || atn_i)) begin
            acc_q <= hs_coding_pkg::ACC_IDLE;
          end
        end
        hs_coding_pkg::ACC_ACCEPT: begin
          acc_q <= hs_coding_pkg::ACC_DONE;
        end
        hs_coding_pkg::ACC_DONE: begin
          // Valid withdrawn: drop accepted before the next cycle.
          if (!dav_i) begin
            acc_q <= hs_coding_pkg::ACC_IDLE;
          end
        end
        default: begin
          acc_q <= hs_coding_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  // Ready in the ready state; accepted after the byte is taken.
  assign rfd_o      = (acc_q == hs_coding_pkg::ACC_READY);
  assign dac_o      = (acc_q == hs_coding_pkg::ACC_DONE);
  assign rfd_oe_n_o = !rfd_o;
  assign dac_oe_n_o = !dac_o;

  // Received byte captured only in the accept state.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_o  <= 8'h00;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= rx_strobe && !atn_i;
      if (rx_strobe) begin
        rx_data_o <= dio_i;
      end
    end
  end

  ////////////////////////////////////////
  // Command decode.

  logic d_ml, d_mt, d_ul, d_ut, d_ot, d_un, d_ad, d_se;  // Raw decode pulses.
  logic cmd_strobe;     // Command byte taken under attention.

  assign cmd_strobe = rx_strobe && atn_i;

  cmd_decoder u_dec (
    .clk_i        (ref_clk_i),
    .rst_n_i      (rst_n),
    .valid_i      (cmd_strobe),
    .byte_i       (dio_i),
    .my_addr_i    (my_addr_i),
    .my_listen_o  (d_ml),
    .my_talk_o    (d_mt),
    .unlisten_o   (d_ul),
    .untalk_o     (d_ut),
    .other_talk_o (d_ot),
    .univ_o       (d_un),
    .addrd_o      (d_ad),
    .sec_o        (d_se)
  );

  logic lstn_q;     // Addressed as listener.
  logic talk_q;     // Addressed as talker.
  logic prim_q;     // Last command byte was a primary.
  logic cmd_seen_q; // A command byte is being decoded this cycle.

  // Address state; interface clear drops both roles at once.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lstn_q <= 1'b0;
      talk_q <= 1'b0;
    end else if (ifc_i) begin
      lstn_q <= 1'b0;
      talk_q <= 1'b0;
    end else begin
      if (d_ml) begin
        lstn_q <= 1'b1;
      end else if (d_ul) begin
        lstn_q <= 1'b0;
      end
      if (d_mt) begin
        talk_q <= 1'b1;
      end else if (d_ut || d_ot) begin
        talk_q <= 1'b0;
      end
    end
  end

  // Primary tracker: any non-secondary byte arms it, even another device's
  // listen address, which raises no decode pulse; a secondary consumes it.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_seen_q <= 1'b0;
      prim_q     <= 1'b0;
    end else begin
      cmd_seen_q <= cmd_strobe;
      if (cmd_seen_q && !d_se) begin
        prim_q <= 1'b1;
      end else if (d_se || !atn_i) begin
        prim_q <= 1'b0;
      end
    end
  end

  assign listener_o  = lstn_q;
  assign talker_o    = talk_q;
  assign my_listen_o = d_ml;
  assign my_talk_o   = d_mt;
  assign unlisten_o  = d_ul;
  assign untalk_o    = d_ut;
  assign univ_cmd_o  = d_un;
  assign addrd_cmd_o = d_ad && (lstn_q || talk_q);
  assign sec_cmd_o   = d_se && prim_q;

  // Pin polarity: the bus is negative logic, inverted by the transceivers.
  // Nothing here inverts; every pin is the positive-logic complement.

endmodule : bus_handshake

// ===== verification/bus_handshake_checker.sv
// Purpose: Port-level assertions for the bus handshake block.
// Assumes: One clock domain; nrst_i low mutes every check.
// Notes:   Attached by the bind below; judges design outputs only.
`timescale 1ns/1ps
module bus_handshake_checker (
  input wire logic       ref_clk_i,
  input wire logic       nrst_i,
  input wire logic       atn_i,
  input wire logic       rx_enable_i,
  input wire logic       dav_i,
  input wire logic       rfd_i,
  input wire logic       dac_i,
  input wire logic       atn_o,
  input wire logic       tx_ready_o,
  input wire logic       tx_done_o,
  input wire logic       rx_valid_o,
  input wire logic       addrd_cmd_o,
  input wire logic       listener_o,
  input wire logic       talker_o,
  input wire logic       dav_o,
  input wire logic       dav_oe_n_o,
  input wire logic       rfd_o,
  input wire logic       dac_o,
  input wire logic [7:0] dio_o
);
  ////////////////////////////////////////
  // One clock; reset mutes all checks.
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////
  // Source side checks.
  dav_ready_a: assert property ($rose(dav_o) |-> $past(rfd_i) && !$past(dac_i))
    else $error("valid without ready");
  data_hold_a: assert property (dav_o |-> $stable(dio_o))
    else $error("data lines moved while valid");
  dav_withdraw_a: assert property (dav_o && dac_i |=> !dav_o)
    else $error("data valid kept after acceptance");
  tx_done_a: assert property (dav_o && dac_i |-> ##[1:2] tx_done_o)
    else $error("no completion pulse");
  dav_passive_a: assert property (dav_oe_n_o == !dav_o)
    else $error("data valid driver enabled while passive");
  atn_refuse_a: assert property (atn_i |-> !tx_ready_o && atn_o)
    else $error("send accepted during attention");
  ////////////////////////////////////////
  // Acceptor side checks.
  rfd_entry_a: assert property ($rose(rfd_o) |-> !$past(dav_i) && !dac_o)
    else $error("ready raised while data still valid");
  accept_seq_a: assert property (rfd_o && dav_i && (rx_enable_i || atn_i)
    |=> !rfd_o && !dac_o ##1 dac_o)
    else $error("accept sequence broken");
  dac_release_a: assert property (dac_o && !dav_i |=> !dac_o)
    else $error("accepted held too long");
  rx_strobe_a: assert property (rx_valid_o |-> dac_o && !rfd_o)
    else $error("byte strobe outside accept");
  addressed_only_a: assert property (addrd_cmd_o |-> listener_o || talker_o)
    else $error("addressed command while unaddressed");
endmodule : bus_handshake_checker

bind bus_handshake bus_handshake_checker bus_handshake_checker_inst (.*);

// ===== verification/far_end_model.sv
// Purpose: Far-end acceptor and talker on the wired lines.
// Assumes: Positive-logic pin view; a released ready or accepted line reads 1.
// Notes:   Acceptor may be slowed or removed.
`timescale 1ns/1ps
module far_end (
  input  wire logic       clk_i,     // Block clock.
  input  wire logic       acc_on_i,  // Acceptor present on the bus.
  input  wire logic [3:0] slow_i,    // Extra cycles before accepting.
  input  wire logic       dav_w_i,   // Wired data valid.
  input  wire logic       rfd_w_i,   // Wired ready for data.
  input  wire logic       dac_w_i,   // Wired data accepted.
  input  wire logic [7:0] dio_w_i,   // Wired data lines.
  output logic            bus_dav_o, // Data valid.
  output logic            bus_rfd_o, // Ready, 1 = released.
  output logic            bus_dac_o, // Accepted, 1 = released.
  output logic [7:0]      bus_dio_o  // Data, 0 = passive.
);
  logic [7:0] got[$];   // Bytes this acceptor has taken.
  logic [1:0] st_q;     // Acceptor step.
  logic [3:0] cnt_q;    // Slowness countdown.

  ////////////////////////////////////////
  // Power-up quiet state.
  initial begin
    bus_dav_o = 1'b0;
    bus_dio_o = 8'h00;
    bus_rfd_o = 1'b0;
    bus_dac_o = 1'b0;
    st_q = 2'h0;
    cnt_q = 4'h0;
  end

  ////////////////////////////////////////
  // Acceptor; when absent both lines float high.
  always @(posedge clk_i) begin
    if (!acc_on_i) begin
      bus_rfd_o <= 1'b1;
      bus_dac_o <= 1'b1;
      st_q <= 2'h0;
    end else begin
      case (st_q)
        2'h0: begin
          bus_rfd_o <= 1'b0;
          bus_dac_o <= 1'b0;
          if (!dav_w_i) st_q <= 2'h1;
        end
        2'h1: if (dav_w_i) begin
          bus_rfd_o <= 1'b0;
          got.push_back(dio_w_i);
          cnt_q <= slow_i;
          st_q <= 2'h2;
        end else bus_rfd_o <= 1'b1;
        2'h2: if (cnt_q == 4'h0) begin
          bus_dac_o <= 1'b1;
          st_q <= 2'h3;
        end else cnt_q <= cnt_q - 4'h1;
        default: if (!dav_w_i) begin
          bus_dac_o <= 1'b0;
          st_q <= 2'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////
  // Talker; bounded waits turn a dead peer into a missing byte.
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    while (!(rfd_w_i && !dac_w_i) && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    bus_dio_o <= b;
    repeat (2) @(posedge clk_i);
    bus_dav_o <= 1'b1;
    n = 0;
    while (!dac_w_i && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    bus_dav_o <= 1'b0;
    bus_dio_o <= 8'h00;
  endtask : send
endmodule : far_end

// ===== verification/tb.sv
// Purpose: Self-checking bench for the bus handshake block.
// Assumes: The far-end model is the only other instrument on the bus.
// Notes:   Expected values come from a bench model.
`timescale 1ns/1ps
module tb;
  logic       ref_clk_i = 1'b0, nrst_i = 1'b0, tx_valid_i = 1'b0, rx_enable_i = 1'b0;
  logic       rx_hold_i = 1'b0, atn_i = 1'b0, ifc_i = 1'b0, ren_i = 1'b0, acc_on = 1'b0;
  logic [4:0] my_addr_i = 5'h00;
  logic [7:0] tx_data_i = 8'h00, rx_data_o, dio_o, dio_i, m_dio;
  logic [3:0] slow = 4'h0;
  logic tx_ready_o, tx_done_o, src_err_o, rx_valid_o, my_listen_o, my_talk_o, unlisten_o;
  logic untalk_o, addrd_cmd_o, univ_cmd_o, sec_cmd_o, listener_o, talker_o, atn_o, ifc_o;
  logic ren_o, dav_o, dav_oe_n_o, rfd_o, rfd_oe_n_o, dac_o, dac_oe_n_o, dio_oe_n_o;
  logic dav_i, rfd_i, dac_i, m_dav, m_rfd, m_dac, lst = 1'b0, tlk = 1'b0, prim = 1'b0;
  logic [6:0] ev;        // Decode pulses seen since last clear.
  logic [7:0] rxq[$];    // Data bytes the design reported.
  logic [7:0] fixed [12] = '{8'h65, 8'h01, 8'h65, 8'h65, 8'h20, 8'h84, 8'h3F, 8'hC0,
                             8'h02, 8'h5F, 8'h03, 8'h11};
  int         err_count = 0, comparisons = 0, seed = 32'h24d16f58;

  always #25 ref_clk_i = ~ref_clk_i;
  // Wired lines; a disabled acceptor releases its lines.
  assign dav_i = m_dav | (dav_o & !dav_oe_n_o);
  assign rfd_i = m_rfd & ((rx_enable_i | atn_i) ? rfd_o : 1'b1);
  assign dac_i = m_dac & ((rx_enable_i | atn_i) ? dac_o : 1'b1);
  assign dio_i = m_dio | (dio_oe_n_o ? 8'h00 : dio_o);

  bus_handshake #(.SETTLE(2)) bus_handshake_inst (.*);
  far_end far_end_inst (.clk_i(ref_clk_i), .acc_on_i(acc_on), .slow_i(slow), .dav_w_i(dav_i),
    .rfd_w_i(rfd_i), .dac_w_i(dac_i), .dio_w_i(dio_i), .bus_dav_o(m_dav), .bus_rfd_o(m_rfd),
    .bus_dac_o(m_dac), .bus_dio_o(m_dio));

  // Gather pulses on the falling edge.
  always @(negedge ref_clk_i) begin
    ev <= ev | {my_listen_o, my_talk_o, unlisten_o, untalk_o, addrd_cmd_o, univ_cmd_o,
                sec_cmd_o};
    if (rx_valid_o === 1'b1) rxq.push_back(rx_data_o);
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // Bounded wait for ready (sel 0) or completion (sel 1).
  task automatic wait_for(input int sel);
    for (int n = 0; n < 600; n++) begin
      @(negedge ref_clk_i);
      if ((sel == 0 ? tx_ready_o : tx_done_o) === 1'b1) return;
    end
    err_count++;
    results();
  endtask : wait_for

  // Offer a byte and hold it until the edge that takes it.
  task automatic offer(input logic [7:0] b);
    @(posedge ref_clk_i);
    tx_valid_i <= 1'b1;
    tx_data_i <= b;
    wait_for(0);
    @(posedge ref_clk_i);
    tx_valid_i <= 1'b0;
  endtask : offer

  initial begin
    int         i;
    logic [7:0] b;
    logic [6:0] e;
    ev = 7'h00;
    @(posedge ref_clk_i);
    chk("reset_lines", {dav_o, rfd_o, dac_o}, 8'h00);
    @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    acc_on <= 1'b1;
    // Design as source, fast and slow acceptor.
    for (i = 0; i < 8; i++) begin
      slow <= i[0] ? 4'h6 : 4'h0;
      b = 8'($random(seed));
      offer(b);
      wait_for(1);
      chk("tx_byte", far_end_inst.got.pop_front(), b);
      chk("src_err", src_err_o, 1'b0);
    end
    repeat (3) @(posedge ref_clk_i);
    acc_on <= 1'b0;
    offer(8'hA5);
    repeat (10) @(posedge ref_clk_i);
    chk("no_acceptor", {src_err_o, dav_o}, 8'h02);
    acc_on <= 1'b1;
    wait_for(1);
    chk("late_byte", far_end_inst.got.pop_front(), 8'hA5);
    // Design as acceptor.
    acc_on <= 1'b0;
    rx_enable_i <= 1'b1;
    rx_hold_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    chk("held_ready", rfd_o, 1'b0);
    rx_hold_i <= 1'b0;
    for (i = 0; i < 8; i++) begin
      b = 8'($random(seed));
      far_end_inst.send(b);
      repeat (3) @(posedge ref_clk_i);
      chk("rx_count", rxq.size(), 8'h01);
      chk("rx_byte", rxq.pop_front(), b);
    end
    // Command bytes under attention.
    b = 8'($random(seed));
    my_addr_i <= {1'b0, b[3:0]};
    atn_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk("tx_refused", tx_ready_o, 1'b0);
    for (i = 0; i < 48; i++) begin
      b = (i < 12) ? fixed[i] : 8'($random(seed));
      if (b[6:0] == 7'h7F) b[0] = 1'b0;
      if ((i < 12) ? ((b[6] ^ b[5]) && b[4:0] == 5'h00) : b[7]) b[4:0] = my_addr_i;
      e = 7'h00;
      case (b[6:5])
        2'h1: if (b[4:0] == 5'h1F) {e[4], lst} = 2'b10;
              else if (b[4:0] == my_addr_i) {e[6], lst} = 2'b11;
        2'h2: if (b[4:0] == 5'h1F) {e[3], tlk} = 2'b10;
              else if (b[4:0] == my_addr_i) {e[5], tlk} = 2'b11;
              else tlk = 1'b0;
        2'h0: if (b[4]) e[1] = 1'b1;
              else e[2] = lst | tlk;
        default: e[0] = prim;
      endcase
      prim = (b[6:5] != 2'h3);
      ren_i <= b[3];
      ev = 7'h00;
      far_end_inst.send(b);
      repeat (4) @(posedge ref_clk_i);
      chk("cmd_events", ev, e);
      chk("addressed", {listener_o, talker_o}, {lst, tlk});
      chk("uniline", {atn_o, ifc_o, ren_o}, {atn_i, ifc_i, ren_i});
      chk("cmd_no_data", rxq.size(), 8'h00);
    end
    // Interface clear drops addressing.
    far_end_inst.send({3'h1, my_addr_i});
    ifc_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk("ifc_clear", {ifc_o, listener_o, talker_o}, 8'h04);
    ifc_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    results();
  end
endmodule : tb
